// >>> gpio_port_edge_irq.sv
// two 8-bit gpio ports with alternate functions and shared edge interrupt
`timescale 1ns/100ps
`default_nettype none

//
// Contract
// - direction zero makes pin an input
// - register bit x serves pin x
// - input pin reads its synchronised level
// - direction one makes pin driven output
// - written data latched and driven out
// - output pin reads back the latch
// - output pins never raise interrupts
// - alternate function overrides direction and data
// - peripheral drive forces push-pull or open-drain
// - peripheral input pin stays readable input
// - enable register at 08, reset 00
// - sources 1,2,5,6 fire on rising edge
// - sources 3,4,7,8 fire on falling edge
// - disabled or other pins never interrupt
// - enabled sources ORed into one request
// - data and direction reset to zero
// - request passes only while cpu unmasked
module gpio_port_edge_irq (
   // clock and reset
   input wire logic clock_i,
   input wire logic resetn_i,
   // register port
   input wire logic [gpio_edge_pkg::ADDR_W-1:0] addr_i,
   input wire logic [gpio_edge_pkg::DATA_W-1:0] wdata_i,
   input wire logic write_i,
   input wire logic read_i,
   output logic [gpio_edge_pkg::DATA_W-1:0] rdata_o,
   // cpu interrupt side
   input wire logic irq_mask_i,
   output logic irq_o,
   // port a pins
   input wire logic [7:0] porta_pin_i,
   output logic [7:0] porta_pin_o,
   output logic [7:0] porta_pin_oe_n_o,
   // port a alternate functions
   input wire logic [7:0] porta_alt_drive_i,
   input wire logic [7:0] porta_alt_value_i,
   input wire logic [7:0] porta_alt_open_drain_i,
   output logic [7:0] porta_periph_in_o,
   // port b pins
   input wire logic [7:0] portb_pin_i,
   output logic [7:0] portb_pin_o,
   output logic [7:0] portb_pin_oe_n_o,
   // port b alternate functions
   input wire logic [7:0] portb_alt_drive_i,
   input wire logic [7:0] portb_alt_value_i,
   input wire logic [7:0] portb_alt_open_drain_i,
   output logic [7:0] portb_periph_in_o
);
   import gpio_edge_pkg::*;

   localparam int NPORT = 2;

   logic [NPORT-1:0][7:0] pin_meta;
   logic [NPORT-1:0][7:0] pin_sync;
   logic [NPORT-1:0][7:0] port_value_latch;
   logic [NPORT-1:0][7:0] dir;
   logic [NPORT-1:0][7:0] pin_out;
   logic [NPORT-1:0][7:0] pin_oe_n;
   logic [7:0] edge_interrupt_enables;
   logic src_any_q;
   logic irq;
   logic [7:0] rdata;

   wire [NPORT-1:0][7:0] pin_raw;
   wire [NPORT-1:0][7:0] alt_drive;
   wire [NPORT-1:0][7:0] alt_value;
   wire [NPORT-1:0][7:0] alt_od;
   wire [NPORT-1:0][7:0] next_pin_out;
   wire [NPORT-1:0][7:0] next_pin_oe_n;
   wire [NPORT-1:0][7:0] in_mode;
   wire [NPORT-1:0][7:0] port_read;
   wire [NPORT-1:0][SRC_PER_PORT-1:0] ext_irq_source;
   wire [NPORT-1:0] sel_data;
   wire [NPORT-1:0] sel_dir;
   wire sel_en;
   wire src_any;
   wire next_irq;
   wire [7:0] rd_mux;

   // gather per-port inputs so both ports share one description
   assign pin_raw = {portb_pin_i, porta_pin_i};
   assign alt_drive = {portb_alt_drive_i, porta_alt_drive_i};
   assign alt_value = {portb_alt_value_i, porta_alt_value_i};
   assign alt_od = {portb_alt_open_drain_i, porta_alt_open_drain_i};

   // address decode
   assign sel_data[0] = (addr_i == REG_PA_DATA);
   assign sel_data[1] = (addr_i == REG_PB_DATA);
   assign sel_dir[0] = (addr_i == REG_PA_DIR);
   assign sel_dir[1] = (addr_i == REG_PB_DIR);
   assign sel_en = (addr_i == REG_EDGE_EN);

   genvar p;
   generate
      for (p = 0; p < NPORT; p++)
      begin : g_port
         // bitwise pin mapping; direction sets drive
         // peripheral drive wins; open drain only pulls low
         assign next_pin_out[p] = (alt_drive[p] & ~alt_od[p] & alt_value[p])
            | (~alt_drive[p] & port_value_latch[p]);
         assign next_pin_oe_n[p] = ~((alt_drive[p] & (~alt_od[p] | ~alt_value[p]))
            | (~alt_drive[p] & dir[p]));
         // only true inputs may feed the interrupt
         assign in_mode[p] = ~dir[p] & ~alt_drive[p];
         // input reads the pin, output reads the latch
         assign port_read[p] = (dir[p] & port_value_latch[p]) | (~dir[p] & pin_sync[p]);
         // rise on pins 5..4, fall on pins 7..6, enabled only
         assign ext_irq_source[p] =
            edge_interrupt_enables[p*SRC_PER_PORT +: SRC_PER_PORT]
            & in_mode[p][SRC_PIN_LO +: SRC_PER_PORT]
            & {~pin_sync[p][7:6], pin_sync[p][5:4]};
      end
   endgenerate

   // one shared request; an active level on one pin hides the others
   assign src_any = |ext_irq_source;
   // edge of the shared level, gated by the cpu mask
   assign next_irq = src_any & ~src_any_q & ~irq_mask_i;

   // read selection; unmapped offsets read zero
   assign rd_mux = sel_data[0] ? port_read[0] :
                   sel_dir[0] ? dir[0] :
                   sel_data[1] ? port_read[1] :
                   sel_dir[1] ? dir[1] :
                   sel_en ? edge_interrupt_enables : RD_UNMAPPED;

   // two-flop pin synchroniser; metastable stage read only here and in a_sync_chain
   always_ff @(posedge clock_i or negedge resetn_i)
   begin
      if (!resetn_i)
      begin
         pin_meta <= '0;
         pin_sync <= '0;
      end
      else
      begin
         pin_meta <= pin_raw;
         pin_sync <= pin_meta;
      end
   end

   // software registers; data latch takes writes even in input mode
   always_ff @(posedge clock_i or negedge resetn_i)
   begin
      if (!resetn_i)
      begin
         port_value_latch <= {RST_DATA, RST_DATA};
         dir <= {RST_DIR, RST_DIR};
         edge_interrupt_enables <= RST_EDGE_EN;
      end
      else if (write_i)
      begin
         for (int i = 0; i < NPORT; i++)
         begin
            if (sel_data[i])
               port_value_latch[i] <= wdata_i;
            if (sel_dir[i])
               dir[i] <= wdata_i;
         end
         if (sel_en)
            edge_interrupt_enables <= wdata_i;
      end
   end

   // registered pin drive, read data and interrupt pulse
   always_ff @(posedge clock_i or negedge resetn_i)
   begin
      if (!resetn_i)
      begin
         pin_out <= '0;
         pin_oe_n <= '1;
         src_any_q <= 1'b0;
         irq <= 1'b0;
         rdata <= RD_UNMAPPED;
      end
      else
      begin
         pin_out <= next_pin_out;
         pin_oe_n <= next_pin_oe_n;
         src_any_q <= src_any;
         irq <= next_irq;
         // data valid only in the cycle after the strobe
         rdata <= read_i ? rd_mux : RD_UNMAPPED;
      end
   end

   // outputs straight from flops
   assign rdata_o = rdata;
   assign irq_o = irq;
   assign porta_pin_o = pin_out[0];
   assign portb_pin_o = pin_out[1];
   assign porta_pin_oe_n_o = pin_oe_n[0];
   assign portb_pin_oe_n_o = pin_oe_n[1];
   assign porta_periph_in_o = pin_sync[0];
   assign portb_periph_in_o = pin_sync[1];

   // checks
   default clocking cb @(posedge clock_i); endclocking
   default disable iff (!resetn_i);

   sequence s_en_write;
      write_i && sel_en;
   endsequence
   sequence s_en_read;
      read_i && !write_i && sel_en;
   endsequence

   a_rdata_idle: assert property (!read_i |=> rdata_o == 8'h00)
      else $error("read data not zero outside read cycle");
   a_read_input:
      assert property (read_i && sel_data[0] && dir[0] == 8'h00
         |=> rdata_o == $past(pin_sync[0]))
      else $error("input pin read does not return pin level");
   a_read_latch:
      assert property (read_i && sel_data[0] && dir[0] == 8'hFF
         |=> rdata_o == $past(port_value_latch[0]))
      else $error("output pin read does not return latch");
   a_read_latch_b:
      assert property (read_i && sel_data[1] && dir[1] == 8'hFF
         |=> rdata_o == $past(port_value_latch[1]))
      else $error("port b output read does not return latch");
   // data latch takes every write, even in input mode
   a_latch_write:
      assert property (write_i && sel_data[0] |=> port_value_latch[0] == $past(wdata_i))
      else $error("port data latch missed a write");
   a_write_drive:
      assert property (write_i && sel_data[0] && dir[0] == 8'hFF
         && porta_alt_drive_i == 8'h00 ##1 (!write_i && porta_alt_drive_i == 8'h00
         && dir[0] == 8'hFF) |=> porta_pin_o == $past(wdata_i, 2))
      else $error("written data not driven on pin");
   a_input_float:
      assert property (dir[0] == 8'h00 && porta_alt_drive_i == 8'h00
         |=> porta_pin_oe_n_o == 8'hFF)
      else $error("input pin is being driven");
   // port b input releases the pin
   a_input_float_b:
      assert property (dir[1] == 8'h00 && portb_alt_drive_i == 8'h00
         |=> portb_pin_oe_n_o == 8'hFF)
      else $error("port b input pin is being driven");
   a_output_drive:
      assert property (dir[1] == 8'hFF && portb_alt_drive_i == 8'h00
         |=> portb_pin_oe_n_o == 8'h00)
      else $error("output pin not driven");
   a_alt_override:
      assert property (porta_alt_drive_i[0] && !porta_alt_open_drain_i[0]
         |=> porta_pin_o[0] == $past(porta_alt_value_i[0]) && !porta_pin_oe_n_o[0])
      else $error("alternate function did not override pin");
   a_alt_open_drain:
      assert property (porta_alt_drive_i[1] && porta_alt_open_drain_i[1]
         && porta_alt_value_i[1] |=> porta_pin_oe_n_o[1])
      else $error("open drain pin driven high");
   a_en_readback:
      assert property (s_en_write ##1 s_en_read
         |=> rdata_o == $past(wdata_i, 2))
      else $error("enable register readback mismatch");
   // writes elsewhere leave the enables alone
   a_en_hold:
      assert property (write_i && !sel_en |=> $stable(edge_interrupt_enables))
      else $error("enable register changed without a write to it");
   // no output pin keeps a live source, per pin
   a_output_quiet:
      assert property (((dir[0][7:4] | porta_alt_drive_i[7:4]) & ext_irq_source[0]) == 4'h0
         && ((dir[1][7:4] | portb_alt_drive_i[7:4]) & ext_irq_source[1]) == 4'h0)
      else $error("output pin produced interrupt source");
   a_rise_source:
      assert property (edge_interrupt_enables[0] && in_mode[0][4]
         && pin_sync[0][4] |-> src_any)
      else $error("rising source not seen");
   a_fall_source:
      assert property (edge_interrupt_enables[6] && in_mode[1][6]
         && !pin_sync[1][6] |-> src_any)
      else $error("falling source not seen");
   // second synchroniser flop follows the first
   a_sync_chain:
      assert property (1'b1 |=> porta_periph_in_o == $past(pin_meta[0])
         && portb_periph_in_o == $past(pin_meta[1]))
      else $error("pin level skipped the synchroniser chain");
   a_disabled_quiet: assert property (edge_interrupt_enables == 8'h00 |=> !irq_o)
      else $error("interrupt with all sources disabled");
   // pulse follows an edge of the shared level
   a_irq_edge: assert property (irq_o |-> $past(src_any) && !$past(src_any_q))
      else $error("interrupt without edge");
   a_irq_single: assert property (irq_o |=> !irq_o)
      else $error("interrupt pulse longer than one clock");
   a_irq_masked: assert property (irq_o |-> !$past(irq_mask_i))
      else $error("interrupt passed while masked");
endmodule

`default_nettype wire

// >>> gpio_edge_pkg.sv
// constants shared by the edge-interrupt gpio port block
package gpio_edge_pkg;
   // register bus geometry
   localparam int ADDR_W = 4;
   localparam int DATA_W = 8;
   // register offsets, as register indices on the plain port
   localparam logic [3:0] REG_PA_DATA = 4'h0;
   localparam logic [3:0] REG_PA_DIR = 4'h1;
   localparam logic [3:0] REG_PB_DATA = 4'h2;
   localparam logic [3:0] REG_PB_DIR = 4'h3;
   localparam logic [3:0] REG_EDGE_EN = 4'h8;
   // reset values
   localparam logic [7:0] RST_DATA = 8'h00;
   localparam logic [7:0] RST_DIR = 8'h00;
   localparam logic [7:0] RST_EDGE_EN = 8'h00;
   localparam logic [7:0] RD_UNMAPPED = 8'h00;
   // interrupt source layout: four sources per port on pins 7..4,
   // pins 5..4 rise-sensitive, pins 7..6 fall-sensitive
   localparam int SRC_PER_PORT = 4;
   localparam int SRC_PIN_LO = 4;
endpackage

// >>> pin_wire_model.sv
// model of the package pins and the outside world on one 8-bit port
`timescale 1ns/100ps
`default_nettype none

module pin_wire_model (
   // what the port drives
   input wire logic [7:0] out_i,
   input wire logic [7:0] oe_n_i,
   // level that the outside world puts on undriven pins
   input wire logic [7:0] ext_i,
   // resolved wire level
   output logic [7:0] level_o
);
   // per bit, the port wins where it drives, else the outside level stands
   assign level_o = (~oe_n_i & out_i) | (oe_n_i & ext_i);
endmodule
`default_nettype wire

// >>> gpio_port_edge_irq_tb.sv
// self-checking bench for the edge-interrupt gpio port
`timescale 1ns/100ps
`default_nettype none

module gpio_port_edge_irq_tb;
   import gpio_edge_pkg::*;
   logic clock_i = 1'b0;
   logic resetn_i = 1'b0;
   logic write_i = 1'b0;
   logic read_i = 1'b0;
   logic irq_mask_i = 1'b0;
   logic [3:0] addr_i = 4'h0;
   logic [7:0] wdata_i = 8'h00;
   logic [7:0] rdata_o;
   logic irq_o;
   // idle levels keep every edge source inactive
   logic [15:0] ext = 16'hC0C0;
   logic [15:0] alt_d = 16'h0000;
   logic [15:0] alt_v = 16'h0000;
   logic [15:0] alt_od = 16'h0000;
   wire logic [15:0] pin_o;
   wire logic [15:0] oe_n;
   wire logic [15:0] lvl;
   wire logic [15:0] pin_in;
   int n_fail = 0;
   int checks_done = 0;
   int seed = 44;
   int idx;
   logic act;
   logic [7:0] m_data [2];
   logic [7:0] m_dir [2];

   gpio_port_edge_irq dut (.clock_i(clock_i), .resetn_i(resetn_i), .addr_i(addr_i),
      .wdata_i(wdata_i), .write_i(write_i), .read_i(read_i), .rdata_o(rdata_o),
      .irq_mask_i(irq_mask_i), .irq_o(irq_o), .porta_pin_i(lvl[7:0]),
      .porta_pin_o(pin_o[7:0]), .porta_pin_oe_n_o(oe_n[7:0]),
      .porta_alt_drive_i(alt_d[7:0]), .porta_alt_value_i(alt_v[7:0]),
      .porta_alt_open_drain_i(alt_od[7:0]), .porta_periph_in_o(pin_in[7:0]),
      .portb_pin_i(lvl[15:8]), .portb_pin_o(pin_o[15:8]), .portb_pin_oe_n_o(oe_n[15:8]),
      .portb_alt_drive_i(alt_d[15:8]), .portb_alt_value_i(alt_v[15:8]),
      .portb_alt_open_drain_i(alt_od[15:8]), .portb_periph_in_o(pin_in[15:8]));
   pin_wire_model wire_a (.out_i(pin_o[7:0]), .oe_n_i(oe_n[7:0]), .ext_i(ext[7:0]),
      .level_o(lvl[7:0]));
   pin_wire_model wire_b (.out_i(pin_o[15:8]), .oe_n_i(oe_n[15:8]), .ext_i(ext[15:8]),
      .level_o(lvl[15:8]));

   always #50 clock_i = ~clock_i;

   // model: which bits the port drives, and the value it drives
   function automatic logic [7:0] mdrv(input int p);
      return (alt_d[p*8+:8] & ~(alt_od[p*8+:8] & alt_v[p*8+:8])) | (~alt_d[p*8+:8] & m_dir[p]);
   endfunction
   function automatic logic [7:0] mout(input int p);
      return (alt_d[p*8+:8] & alt_v[p*8+:8]) | (~alt_d[p*8+:8] & m_data[p]);
   endfunction
   function automatic logic [7:0] mlvl(input int p);
      return (mdrv(p) & mout(p)) | (~mdrv(p) & ext[p*8+:8]);
   endfunction

   task automatic chk8(input string n, input logic [7:0] e, input logic [7:0] g);
      checks_done++;
      if (g !== e)
      begin
         n_fail++;
         $display("MISMATCH %s exp %h got %h", n, e, g);
      end
   endtask

   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge clock_i);
      addr_i <= a;
      wdata_i <= d;
      write_i <= 1'b1;
      @(posedge clock_i);
      write_i <= 1'b0;
      if (a == REG_PA_DATA) m_data[0] = d;
      if (a == REG_PA_DIR) m_dir[0] = d;
      if (a == REG_PB_DATA) m_data[1] = d;
      if (a == REG_PB_DIR) m_dir[1] = d;
   endtask

   task automatic rd(input logic [3:0] a, input logic [7:0] e);
      @(posedge clock_i);
      addr_i <= a;
      read_i <= 1'b1;
      @(posedge clock_i);
      read_i <= 1'b0;
      #1 chk8("rdata", e, rdata_o);
   endtask

   // write then read with no idle cycle between the strobes
   task automatic wr_rd(input logic [3:0] a, input logic [7:0] d, input logic [7:0] e);
      @(posedge clock_i);
      addr_i <= a;
      wdata_i <= d;
      write_i <= 1'b1;
      @(posedge clock_i);
      write_i <= 1'b0;
      read_i <= 1'b1;
      @(posedge clock_i);
      read_i <= 1'b0;
      #1 chk8("rdata", e, rdata_o);
   endtask

   task automatic setp(input int i, input logic v);
      @(posedge clock_i);
      ext[i] <= v;
   endtask

   // counts high cycles of the interrupt pulse irq_o over a fixed window
   task automatic irq_win(input int e);
      int n;
      n = 0;
      repeat (6)
      begin
         @(posedge clock_i);
         #1 if (irq_o === 1'b1) n++;
      end
      chk8("irq cycles", 8'(e), 8'(n));
   endtask

   task automatic wrap_up;
      if (n_fail == 0 && checks_done > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask

   // hang guard, far beyond the few hundred cycles the run needs
   initial
   begin
      #400000;
      n_fail++;
      wrap_up;
   end

   initial
   begin
      m_data = '{8'h00, 8'h00};
      m_dir = '{8'h00, 8'h00};
      repeat (3) @(posedge clock_i);
      resetn_i <= 1'b1;
      #1 chk8("oe_n", 8'hFF, oe_n[7:0] & oe_n[15:8]);
      wr(4'h5, 8'hFF);
      rd(4'h5, RD_UNMAPPED);
      rd(REG_PA_DIR, 8'h00);
      rd(REG_PB_DIR, 8'h00);
      rd(REG_EDGE_EN, 8'h00);
      // plain gpio first, then with peripherals taking random pins
      for (int k = 0; k < 4; k++)
         for (int p = 0; p < 2; p++)
         begin
            @(posedge clock_i);
            alt_d[p*8+:8] <= (k > 1) ? 8'($random(seed)) : 8'h00;
            alt_v[p*8+:8] <= 8'($random(seed));
            alt_od[p*8+:8] <= 8'($random(seed));
            ext[p*8+:8] <= 8'($random(seed));
            // data before direction; shared pins stay input in last pass
            wr(4'(p * 2), 8'($random(seed)));
            wr(4'(p * 2 + 1), 8'($random(seed)) & ((k == 3) ? ~alt_d[p*8+:8] : 8'hFF));
            repeat (4) @(posedge clock_i);
            #1 chk8("pin_o", mout(p) & mdrv(p), pin_o[p*8+:8] & mdrv(p));
            chk8("oe_n", ~mdrv(p), oe_n[p*8+:8]);
            chk8("periph_in", mlvl(p), pin_in[p*8+:8]);
            rd(4'(p * 2), (m_dir[p] & m_data[p]) | (~m_dir[p] & mlvl(p)));
         end
      @(posedge clock_i);
      // peripherals off before sources are enabled
      alt_d <= 16'h0000;
      ext <= 16'hC0C0;
      wr(REG_PA_DIR, 8'h00);
      wr(REG_PB_DIR, 8'h00);
      wr_rd(REG_EDGE_EN, 8'h5A, 8'h5A);
      // every source alone: one pulse on its edge, none on the other
      for (int i = 0; i < 8; i++)
      begin
         idx = (i / 4) * 8 + 4 + i % 4;
         act = (i % 4) < 2;
         wr(REG_EDGE_EN, 8'(1 << i));
         setp(idx, act);
         irq_win(1);
         setp(idx, !act);
         irq_win(0);
      end
      wr(REG_EDGE_EN, 8'hFE);
      setp(4, 1'b1);
      setp(0, 1'b1);
      irq_win(0);
      setp(4, 1'b0);
      wr(REG_EDGE_EN, 8'h01);
      wr(REG_PA_DATA, 8'h10);
      wr(REG_PA_DIR, 8'h10);
      irq_win(0);
      wr(REG_PA_DIR, 8'h00);
      wr(REG_EDGE_EN, 8'h03);
      setp(5, 1'b1);
      irq_win(1);
      setp(4, 1'b1);
      irq_win(0);
      setp(4, 1'b0);
      setp(5, 1'b0);
      irq_mask_i <= 1'b1;
      setp(4, 1'b1);
      irq_win(0);
      // mid-run reset: registers clear, then both ports drive, port a pins checked against written data
      @(posedge clock_i);
      resetn_i <= 1'b0;
      @(posedge clock_i);
      resetn_i <= 1'b1;
      m_data = '{8'h00, 8'h00};
      m_dir = '{8'h00, 8'h00};
      rd(REG_EDGE_EN, 8'h00);
      wr(REG_PA_DIR, 8'hFF);
      wr(REG_PB_DIR, 8'hFF);
      #1 chk8("pin_o", 8'h00, pin_o[7:0]);
      wr(REG_PA_DATA, 8'($random(seed)));
      wr(REG_PB_DATA, 8'($random(seed)));
      #1 chk8("pin_o", m_data[0], pin_o[7:0]);
      chk8("oe_n", 8'h00, oe_n[15:8]);
      rd(REG_PA_DATA, m_data[0]);
      rd(REG_PB_DATA, m_data[1]);
      wrap_up;
   end
endmodule
`default_nettype wire
